//--- common/wrf_pkg.sv
// Shared constants of the write-response FIFO
package wrf_pkg;
    // Response code field width and its four outcomes
    localparam int        RESP_W       = 2;
    localparam bit [1:0]  RESP_OKAY    = 2'h0;
    localparam bit [1:0]  RESP_EXOKAY  = 2'h1;
    localparam bit [1:0]  RESP_SLVERR  = 2'h2;
    localparam bit [1:0]  RESP_DECERR  = 2'h3;
    // Default geometry
    localparam int        DEF_DEPTH    = 16;
    localparam int        DEF_ID_W     = 4;
    localparam int        DEF_USER_W   = 1;
    localparam bit        DEF_ECC_EN   = 1'b1;
    // Codeword positions flipped by error injection
    localparam int        INJ_POS_A    = 1;
    localparam int        INJ_POS_B    = 2;
    // Latency from an accepted write into an empty FIFO to valid upstream
    localparam int        FILL_LAT     = 3;
endpackage

//--- rtl/wrf_mem.sv
// Simple dual-port storage with registered read data
`timescale 1ns/1ps
module wrf_mem #(
    parameter int DW = 8,
    parameter int AW = 4
) (
    input  wire logic          clk_in,
    input  wire logic          wr_en_in,
    input  wire logic [AW-1:0] wr_addr_in,
    input  wire logic [DW-1:0] wr_data_in,
    input  wire logic          rd_en_in,
    input  wire logic [AW-1:0] rd_addr_in,
    output logic      [DW-1:0] rd_data_out
);
    logic [DW-1:0] mem_ff [0:(1<<AW)-1];

    // Write port
    always_ff @(posedge clk_in) begin
        if (wr_en_in) begin
            mem_ff[wr_addr_in] <= wr_data_in;
        end
    end

    // Read port, data from a register
    always_ff @(posedge clk_in) begin
        if (rd_en_in) begin
            rd_data_out <= mem_ff[rd_addr_in];
        end
    end
endmodule

//--- rtl/wrf_top.sv
// Write-response channel FIFO with thresholds, ECC and occupancy counts
//
// Operation
// - Stored word packs ID, code, user unchanged
// - Response code is two bits, four outcomes
// - Upstream valid high only when response buffered, three edges after a write to empty
// - Downstream valid/ready pair writes the FIFO
// - Upstream valid/ready pair reads oldest word
// - Full threshold input, settable during reset
// - Empty threshold input, same width, during reset
// - Single-error injection flips one written bit
// - Double-error injection flips two written bits
// - Single-error output on corrected read word
// - Double-error output on uncorrectable read word
// - Overflow flag after refused write, contents intact
// - Overflow may stay low, writes never overfill
// - Underflow flag after refused read, contents intact
// - Underflow may stay low, no empty reads
// - Write count never under-reports stored words
// - Accepted write shows in count next edge
// - User sideband bits travel with each response
// - Programmable full when count at/above threshold
// - Programmable empty when count at/below threshold
// - Read count never over-reports readable words
`timescale 1ns/1ps
module wrf_top #(
    parameter int DEPTH  = wrf_pkg::DEF_DEPTH,
    parameter int ID_W   = wrf_pkg::DEF_ID_W,
    parameter int USER_W = wrf_pkg::DEF_USER_W,
    parameter bit ECC_EN = wrf_pkg::DEF_ECC_EN,
    parameter int AW     = $clog2(DEPTH)
) (
    input  wire logic                       clk_in,
    input  wire logic                       sys_rst_in,
    // Downstream slave side, FIFO write port
    input  wire logic [ID_W-1:0]            m_bid_in,
    input  wire logic [wrf_pkg::RESP_W-1:0] m_bresp_in,
    input  wire logic [USER_W-1:0]          m_buser_in,
    input  wire logic                       m_bvalid_in,
    output logic                            m_bready_out,
    // Upstream master side, FIFO read port
    output logic      [ID_W-1:0]            s_bid_out,
    output logic      [wrf_pkg::RESP_W-1:0] s_bresp_out,
    output logic      [USER_W-1:0]          s_buser_out,
    output logic                            s_bvalid_out,
    input  wire logic                       s_bready_in,
    // Sideband
    input  wire logic [AW-1:0]              prog_full_thresh_in,
    input  wire logic [AW-1:0]              prog_empty_thresh_in,
    input  wire logic                       inject_sbit_in,
    input  wire logic                       inject_dbit_in,
    output logic                            sbit_err_out,
    output logic                            dbit_err_out,
    output logic                            overflow_out,
    output logic                            underflow_out,
    output logic      [AW:0]                wr_cnt_out,
    output logic      [AW:0]                rd_cnt_out,
    output logic      [AW:0]                cnt_out,
    output logic                            prog_full_out,
    output logic                            prog_empty_out
);
    localparam int DW = ID_W + wrf_pkg::RESP_W + USER_W;

    // Number of Hamming check bits for a data width
    function automatic int chk_bits(input int dw);
        int r;
        r = 1;
        while ((1 << r) < dw + r + 1) begin
            r = r + 1;
        end
        return r;
    endfunction

    localparam int R  = chk_bits(DW);
    localparam int CW = ECC_EN ? DW + R + 1 : DW;

    // Elaboration-time checks on geometry
    if (DEPTH < 4 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("DEPTH must be a power of two, at least 4");
    end
    if (ID_W < 1 || USER_W < 1) begin : g_bad_width
        $error("ID_W and USER_W must be at least 1");
    end

    // Whether a codeword position carries a check bit
    function automatic bit is_pow2(input int p);
        return (p != 0) && ((p & (p - 1)) == 0);
    endfunction

    // Extended Hamming encode: bit 0 overall parity, powers of two check bits
    function automatic logic [CW-1:0] ecc_enc(input logic [DW-1:0] d);
        logic [CW-1:0] cw;
        int            k;
        cw = '0;
        k  = 0;
        if (!ECC_EN) begin
            cw[DW-1:0] = d;
        end else begin
            for (int i = 1; i < CW; i++) begin
                if (!is_pow2(i)) begin
                    cw[i] = d[k];
                    k     = k + 1;
                end
            end
            for (int p = 0; p < R; p++) begin
                for (int i = 1; i < CW; i++) begin
                    if (((i >> p) & 1) == 1 && !is_pow2(i)) begin
                        cw[1 << p] = cw[1 << p] ^ cw[i];
                    end
                end
            end
            cw[0] = ^cw;
        end
        return cw;
    endfunction

    // Decode: corrected data plus single and double error indications
    function automatic logic [DW+1:0] ecc_dec(input logic [CW-1:0] c);
        logic [CW-1:0] cw;
        logic [DW-1:0] d;
        int            syn;
        int            k;
        logic          par;
        logic          sgl;
        logic          dbl;
        cw  = c;
        d   = '0;
        syn = 0;
        k   = 0;
        par = 1'b0;
        sgl = 1'b0;
        dbl = 1'b0;
        if (!ECC_EN) begin
            d = cw[DW-1:0];
        end else begin
            for (int i = 1; i < CW; i++) begin
                if (cw[i]) begin
                    syn = syn ^ i;
                end
            end
            par = ^cw;
            sgl = par;
            dbl = !par && (syn != 0);
            if (par && syn != 0 && syn < CW) begin
                cw[syn] = !cw[syn];
            end
            for (int i = 1; i < CW; i++) begin
                if (!is_pow2(i)) begin
                    d[k] = cw[i];
                    k    = k + 1;
                end
            end
        end
        return {sgl, dbl, d};
    endfunction

    logic [AW-1:0] wp_ff;
    logic [AW-1:0] rp_ff;
    logic [AW:0]   mcnt_ff;
    logic [AW:0]   nxt_mcnt;
    logic [AW:0]   nxt_cnt;
    logic          fetch_ff;
    logic          push;
    logic          pop;
    logic          issue;
    logic [CW-1:0] wr_cw;
    logic [CW-1:0] rd_cw;
    logic [DW+1:0] dec;

    // Handshakes on both ports
    assign push  = m_bvalid_in && m_bready_out;
    assign pop   = s_bvalid_out && s_bready_in;
    // Prefetch the oldest stored word once the output stage frees up
    assign issue = (mcnt_ff != '0) && !fetch_ff && (!s_bvalid_out || pop);

    // Packed word with optional fault injection
    always_comb begin
        wr_cw = ecc_enc({m_bid_in, m_bresp_in, m_buser_in});
        if (ECC_EN && inject_dbit_in) begin
            wr_cw[wrf_pkg::INJ_POS_A] = !wr_cw[wrf_pkg::INJ_POS_A];
            wr_cw[wrf_pkg::INJ_POS_B] = !wr_cw[wrf_pkg::INJ_POS_B];
        end else if (ECC_EN && inject_sbit_in) begin
            wr_cw[wrf_pkg::INJ_POS_A] = !wr_cw[wrf_pkg::INJ_POS_A];
        end
    end

    wrf_mem #(
        .DW (CW),
        .AW (AW)
    ) u_mem (
        .clk_in      (clk_in),
        .wr_en_in    (push),
        .wr_addr_in  (wp_ff),
        .wr_data_in  (wr_cw),
        .rd_en_in    (issue),
        .rd_addr_in  (rp_ff),
        .rd_data_out (rd_cw)
    );

    assign dec = ecc_dec(rd_cw);

    // Stored-word and total occupancy next values
    always_comb begin
        nxt_mcnt = mcnt_ff + (AW+1)'(push) - (AW+1)'(issue);
        nxt_cnt  = cnt_out + (AW+1)'(push) - (AW+1)'(pop);
    end

    // Write and read pointers, in order through the ring
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            wp_ff <= '0;
            rp_ff <= '0;
        end else begin
            if (push) begin
                wp_ff <= wp_ff + 1'b1;
            end
            if (issue) begin
                rp_ff <= rp_ff + 1'b1;
            end
        end
    end

    // Storage occupancy and downstream ready
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            mcnt_ff      <= '0;
            m_bready_out <= 1'b0;
        end else begin
            mcnt_ff      <= nxt_mcnt;
            m_bready_out <= (nxt_mcnt < (AW+1)'(DEPTH));
        end
    end

    // Output stage: fetch in flight, then valid word with its error flags
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            fetch_ff     <= 1'b0;
            s_bvalid_out <= 1'b0;
            s_bid_out    <= '0;
            s_bresp_out  <= wrf_pkg::RESP_OKAY;
            s_buser_out  <= '0;
            sbit_err_out <= 1'b0;
            dbit_err_out <= 1'b0;
        end else begin
            fetch_ff <= issue;
            if (fetch_ff) begin
                s_bvalid_out <= 1'b1;
                {s_bid_out, s_bresp_out, s_buser_out} <= dec[DW-1:0];
                sbit_err_out <= dec[DW+1];
                dbit_err_out <= dec[DW];
            end else if (pop) begin
                s_bvalid_out <= 1'b0;
                sbit_err_out <= 1'b0;
                dbit_err_out <= 1'b0;
            end
        end
    end

    // Refused-request flags, one cycle after the refusal
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            overflow_out  <= 1'b0;
            underflow_out <= 1'b0;
        end else begin
            overflow_out  <= m_bvalid_in && !m_bready_out;
            underflow_out <= s_bready_in && (cnt_out == '0);
        end
    end

    // Occupancy counts and programmable flags
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            cnt_out        <= '0;
            wr_cnt_out     <= '0;
            rd_cnt_out     <= '0;
            prog_full_out  <= 1'b0;
            prog_empty_out <= 1'b1;
        end else begin
            cnt_out        <= nxt_cnt;
            wr_cnt_out     <= nxt_cnt;
            rd_cnt_out     <= nxt_cnt - (AW+1)'(push);
            prog_full_out  <= nxt_cnt >= {1'b0, prog_full_thresh_in};
            prog_empty_out <= nxt_cnt <= {1'b0, prog_empty_thresh_in};
        end
    end

    // Assertions
    sequence s_wr_empty;
        cnt_out == '0 && push && !s_bvalid_out && !fetch_ff;
    endsequence

    sequence s_stall;
        s_bvalid_out && !s_bready_in;
    endsequence

    property p_ready_full;
        @(posedge clk_in) disable iff (sys_rst_in)
        mcnt_ff == (AW+1)'(DEPTH) |-> !m_bready_out;
    endproperty
    a_ready_full: assert property (p_ready_full) else $error("ready high while full");

    property p_cnt_inc;
        @(posedge clk_in) disable iff (sys_rst_in)
        push && !pop |=> wr_cnt_out == $past(wr_cnt_out) + 1'b1;
    endproperty
    a_cnt_inc: assert property (p_cnt_inc) else $error("write not counted next edge");

    property p_fill;
        @(posedge clk_in) disable iff (sys_rst_in)
        s_wr_empty |-> ##3 s_bvalid_out;
    endproperty
    a_fill: assert property (p_fill) else $error("valid late after write to empty");

    property p_empty_novalid;
        @(posedge clk_in) disable iff (sys_rst_in)
        cnt_out == '0 |-> !s_bvalid_out;
    endproperty
    a_empty_novalid: assert property (p_empty_novalid) else $error("valid while empty");

    property p_hold;
        @(posedge clk_in) disable iff (sys_rst_in)
        s_stall |=> s_bvalid_out && $stable(s_bid_out) && $stable(s_bresp_out)
            && $stable(s_buser_out);
    endproperty
    a_hold: assert property (p_hold) else $error("response changed while stalled");

    property p_ovf;
        @(posedge clk_in) disable iff (sys_rst_in)
        m_bvalid_in && !m_bready_out |=> overflow_out;
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow not flagged");

    property p_unf;
        @(posedge clk_in) disable iff (sys_rst_in)
        s_bready_in && cnt_out == '0 |=> underflow_out && $stable(rp_ff);
    endproperty
    a_unf: assert property (p_unf) else $error("underflow not flagged");

    property p_pfull;
        @(posedge clk_in) disable iff (sys_rst_in)
        prog_full_out == (cnt_out >= {1'b0, $past(prog_full_thresh_in)});
    endproperty
    a_pfull: assert property (p_pfull) else $error("prog full mismatch");

    property p_pempty;
        @(posedge clk_in) disable iff (sys_rst_in)
        prog_empty_out == (cnt_out <= {1'b0, $past(prog_empty_thresh_in)});
    endproperty
    a_pempty: assert property (p_pempty) else $error("prog empty mismatch");

    property p_rd_cnt;
        @(posedge clk_in) disable iff (sys_rst_in)
        rd_cnt_out <= cnt_out;
    endproperty
    a_rd_cnt: assert property (p_rd_cnt) else $error("read count over-reports");
endmodule

//--- dv/wrf_far_model.sv
// Far-end model: slave issuing responses and master collecting them
`timescale 1ns/1ps
module wrf_far_model (
    input  wire logic       clk_in,
    input  wire logic       sys_rst_in,
    input  wire logic       stall_in,
    input  wire logic       m_bready_in,
    input  wire logic [3:0] s_bid_in,
    input  wire logic [1:0] s_bresp_in,
    input  wire logic [0:0] s_buser_in,
    input  wire logic       s_bvalid_in,
    input  wire logic       sbit_err_in,
    input  wire logic       dbit_err_in,
    output logic      [3:0] m_bid_out,
    output logic      [1:0] m_bresp_out,
    output logic      [0:0] m_buser_out,
    output logic            m_bvalid_out,
    output logic            inject_sbit_out,
    output logic            inject_dbit_out,
    output logic            s_bready_out
);
    logic [8:0] pend[$];
    logic [8:0] got[$];
    logic [8:0] cur_ff = 9'h000;
    logic       took_ff = 1'b0;

    // Queue a response; bits 8 and 7 request double and single injection
    task automatic send(input logic [8:0] w);
        pend.push_back(w);
    endtask

    // Sample both handshakes on the rising edge
    always @(posedge clk_in) begin
        took_ff = m_bvalid_out && m_bready_in;
        if (s_bvalid_in && s_bready_out) begin
            got.push_back({dbit_err_in, sbit_err_in, s_buser_in, s_bresp_in, s_bid_in});
        end
    end

    // Hold an offer until taken; while idle the lines change every cycle
    always @(negedge clk_in) begin
        s_bready_out <= !stall_in && !sys_rst_in;
        if (sys_rst_in) begin
            m_bvalid_out <= 1'b0;
        end else if (took_ff || !m_bvalid_out) begin
            if (pend.size() > 0) begin
                cur_ff = pend.pop_front();
                m_bvalid_out <= 1'b1;
            end else begin
                cur_ff = ~cur_ff;
                m_bvalid_out <= 1'b0;
            end
        end
    end

    assign {inject_dbit_out, inject_sbit_out, m_buser_out, m_bresp_out, m_bid_out} = cur_ff;
endmodule

//--- dv/testbench.sv
// Self-checking bench for the write-response FIFO
`timescale 1ns/1ps
module testbench;
    logic       clk_in;
    logic       sys_rst_in;
    logic       stall;
    logic [3:0] full_thr;
    logic [3:0] empty_thr;
    logic [3:0] m_bid;
    logic [3:0] s_bid;
    logic [1:0] m_bresp;
    logic [1:0] s_bresp;
    logic [0:0] m_buser;
    logic [0:0] s_buser;
    logic       m_bvalid;
    logic       m_bready;
    logic       s_bvalid;
    logic       s_bready;
    logic       inj_s;
    logic       inj_d;
    logic       sbit;
    logic       dbit;
    logic       ovf;
    logic       udf;
    logic       pfull;
    logic       pempty;
    logic [4:0] wr_cnt;
    logic [4:0] rd_cnt;
    logic [4:0] cnt;
    logic [8:0] expq[$];
    int         failures;
    int         checks;
    int         k;

    wrf_top u_wrf_top (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .m_bid_in(m_bid), .m_bresp_in(m_bresp), .m_buser_in(m_buser),
        .m_bvalid_in(m_bvalid), .m_bready_out(m_bready),
        .s_bid_out(s_bid), .s_bresp_out(s_bresp), .s_buser_out(s_buser),
        .s_bvalid_out(s_bvalid), .s_bready_in(s_bready),
        .prog_full_thresh_in(full_thr), .prog_empty_thresh_in(empty_thr),
        .inject_sbit_in(inj_s), .inject_dbit_in(inj_d),
        .sbit_err_out(sbit), .dbit_err_out(dbit),
        .overflow_out(ovf), .underflow_out(udf),
        .wr_cnt_out(wr_cnt), .rd_cnt_out(rd_cnt), .cnt_out(cnt),
        .prog_full_out(pfull), .prog_empty_out(pempty)
    );

    wrf_far_model u_far (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .stall_in(stall),
        .m_bready_in(m_bready), .s_bid_in(s_bid), .s_bresp_in(s_bresp),
        .s_buser_in(s_buser), .s_bvalid_in(s_bvalid),
        .sbit_err_in(sbit), .dbit_err_in(dbit),
        .m_bid_out(m_bid), .m_bresp_out(m_bresp), .m_buser_out(m_buser),
        .m_bvalid_out(m_bvalid), .inject_sbit_out(inj_s),
        .inject_dbit_out(inj_d), .s_bready_out(s_bready)
    );

    // Compare and count
    task automatic chk(input logic [8:0] g, input logic [8:0] e, input string what);
        checks++;
        if (g !== e) begin
            failures++;
            $display("Error at %0t: %s got %h expected %h", $time, what, g, e);
        end
    endtask

    // Report the counts and end the run
    task automatic give_verdict();
        $display("Counts: %0d checks, %0d failures", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Offer a response and remember what must come out
    task automatic put(input logic [8:0] w);
        u_far.send(w);
        expq.push_back(w);
    endtask

    // Wait for n responses and compare them in order
    task automatic drain(input int n);
        logic [8:0] g;
        logic [8:0] e;
        k = 0;
        while (u_far.got.size() < n && k < 500) begin
            @(negedge clk_in);
            k++;
        end
        if (u_far.got.size() < n) begin
            failures++;
            $display("Error at %0t: drain timeout", $time);
            give_verdict();
        end
        repeat (n) begin
            g = u_far.got.pop_front();
            e = expq.pop_front();
            // Data of an uncorrectable word is not defined, its flags are
            if (e[8]) begin
                g[6:0] = 7'h00;
                e[6:0] = 7'h00;
            end
            chk(g, e, "response");
        end
    endtask

    // 40 MHz clock
    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end

    // Main sequence
    initial begin
        sys_rst_in = 1'b1;
        stall = 1'b0;
        full_thr = 4'h0;
        empty_thr = 4'h0;
        failures = 0;
        checks = 0;
        repeat (10) @(negedge clk_in);
        full_thr = 4'hA;
        empty_thr = 4'h3;
        repeat (10) @(negedge clk_in);
        sys_rst_in = 1'b0;
        repeat (3) @(negedge clk_in);
        chk(9'(m_bready), 9'h001, "ready");
        chk(9'(s_bvalid), 9'h000, "valid when empty");
        chk(9'(pempty), 9'h001, "prog empty");
        chk(9'(udf), 9'h001, "underflow");
        chk(9'(ovf), 9'h000, "no overflow");
        $display("Test reset done");
        // Every response code, distinct IDs, alternating user bits
        for (int i = 0; i < 4; i++) begin
            put({2'b00, i[0], i[1:0], 4'(9 - i)});
        end
        drain(4);
        $display("Test codes done");
        // Stalled master: the slave keeps offering past full
        stall = 1'b1;
        for (int i = 0; i < 20; i++) begin
            put({2'b00, 7'(i * 37)});
        end
        k = 0;
        while (m_bready !== 1'b0 && k < 100) begin
            @(negedge clk_in);
            k++;
        end
        chk(9'(m_bready === 1'b0), 9'h001, "ready falls");
        if (m_bready !== 1'b0) begin
            give_verdict();
        end
        @(negedge clk_in);
        chk(9'(ovf), 9'h001, "overflow");
        chk(9'(udf), 9'h000, "no underflow");
        chk(9'(pfull), 9'h001, "prog full");
        chk(9'(pempty), 9'h000, "prog empty clear");
        chk(9'(wr_cnt >= 5'h10), 9'h001, "write count");
        chk(9'(rd_cnt <= cnt), 9'h001, "read count");
        stall = 1'b0;
        drain(20);
        repeat (2) @(negedge clk_in);
        chk(9'(pfull), 9'h000, "prog full clear");
        chk(9'(pempty), 9'h001, "prog empty again");
        chk(9'(cnt), 9'h000, "count empty");
        $display("Test fill done");
        // One write shows in the count one edge after acceptance
        stall = 1'b1;
        @(posedge clk_in);
        put(9'h05A);
        @(negedge clk_in);
        chk(9'(wr_cnt), 9'h000, "count before");
        @(negedge clk_in);
        chk(9'(wr_cnt), 9'h001, "count after");
        // Valid reaches the master a fixed time after a write to empty
        repeat (wrf_pkg::FILL_LAT - 2) @(negedge clk_in);
        chk(9'(s_bvalid), 9'h000, "valid not yet");
        @(negedge clk_in);
        chk(9'(s_bvalid), 9'h001, "valid after fill");
        stall = 1'b0;
        drain(1);
        $display("Test count done");
        // Single then double error injection
        put(9'h0C5);
        put(9'h13A);
        drain(2);
        $display("Test ecc done");
        give_verdict();
    end
endmodule
